// ### hdl/cpsf_pkg.sv
/*
 * constants, register map and carrier types for the charger profile
 * status flags block.
 * assumes one 50 MHz clock and an APB register bus.
 */
package cpsf_pkg;

    // APB byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_EVENT = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;

    // profile outcome status bit positions
    localparam int BIT_PASS = 0;
    localparam int BIT_DCP = 2;
    localparam int BIT_CUSTOM_PROFILE_FLAG = 3;
    localparam int BIT_NOHS = 7;

    // control register bit positions
    localparam int BIT_HS_EMUL = 0;
    localparam int BIT_CUSTOM_PROFILE_FLAG_HS = 1;
    localparam int BIT_CUSTOM_PROFILE_FLAG_CONST = 2;

    // event register bit positions
    localparam int EV_PASS = 0;
    localparam int EV_DCP = 1;
    localparam int EV_CUSTOM_PROFILE_FLAG = 2;
    localparam int EV_NOHS = 3;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam logic [3:0] EVENT_RESET = 4'h0;

    typedef enum logic [1:0]
    {
        CPSF_IDLE = 2'b00,
        CPSF_PASS = 2'b01,
        CPSF_DCP = 2'b10,
        CPSF_CUSTOM_PROFILE_FLAG = 2'b11
    } cpsf_outcome_type;

    // port behaviour that follows the accepted profile
    typedef struct packed
    {
        logic hs_switch_closed;
        logic const_current_limit;
    } cpsf_port_ctrl_type;

    // charger emulation engine events
    typedef struct packed
    {
        logic new_profile;
        logic dcp_accept;
        logic custom_profile_flag_accept;
        logic cycle_no_handshake_flag;
        logic removal;
        logic attach;
        logic mode_change;
    } cpsf_emul_type;

endpackage : cpsf_pkg

// ### hdl/cpsf_apb_slave.sv
/*
 * APB slave front end: decodes address and yields one-cycle read and
 * write strokes; pready is held high so every access ends in one
 * access cycle.
 * assumes an APB master clocked by core_clk.
 */
`timescale 1ns/10ps
module cpsf_apb_slave
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    // decoded strokes
    output logic wr_stroke,
    output logic rd_stroke,
    output logic addr_hit
);
    wire access = psel & penable;
    assign wr_stroke = access & pwrite;
    assign rd_stroke = access & ~pwrite;
    assign addr_hit = (paddr == cpsf_pkg::ADDR_STATUS)
        | (paddr == cpsf_pkg::ADDR_CONTROL)
        | (paddr == cpsf_pkg::ADDR_EVENT)
        | (paddr == cpsf_pkg::ADDR_MASK);

    // reset_n unused: the front end holds no state
    wire unused_ok = core_clk | reset_n;
endmodule : cpsf_apb_slave

// ### hdl/cpsf_top.sv
/*
 * profile outcome status flags with APB access, event interrupt and the
 * high-speed switch / current limit outputs that follow the outcome.
 * assumes an emulation engine that pulses its events one cycle each, and
 * an APB master on core_clk.
 */
// Decided for this implementation: the address map and the APB interface to the registers.
// What this block does
// - no-handshake flag set only when a dedicated emulation cycle fails.
// - no-handshake flag clears when a new emulation profile applies, unless a failed cycle sets it in the same cycle.
// - custom flag set when device handshakes custom profile; charging_downstream is not checked.
// - custom profile in force: switch follows custom switch setting.
// - custom profile in force: limit mode from custom limit setting.
// - dcp flag set on dcp accept; switch follows emulation switch bit.
// - dcp accepted: port switch uses constant current limiting.
// - pass-through flag in pass mode; switch closed, trip limiting.
// - removal then attach without mode change leaves pass flag clear.
// - toggling first mode select re-arms pass-through reporting.
`timescale 1ns/10ps
module cpsf_top
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // mode and emulation engine
    input wire logic pass_mode,
    input wire logic mode_select_first,
    input wire logic supply_low,
    input wire logic charging_downstream,
    input wire cpsf_pkg::cpsf_emul_type emul,
    // port control
    output logic hs_switch_closed,
    output logic const_current_limit,
    // interrupt
    output logic irq
);
    cpsf_pkg::cpsf_outcome_type outcome;
    cpsf_pkg::cpsf_outcome_type next_outcome;
    logic no_handshake_flag;
    logic pass_armed;
    logic mode_sel_q;
    logic [2:0] control;
    logic [3:0] events;
    logic [3:0] mask;
    logic wr_stroke;
    logic rd_stroke;
    logic addr_hit;

    cpsf_apb_slave u_apb
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .wr_stroke(wr_stroke),
        .rd_stroke(rd_stroke),
        .addr_hit(addr_hit)
    );

    // stroke and address passed in so continuous users re-evaluate
    function automatic logic wr_hit(input logic stroke,
        input logic [7:0] addr, input logic [7:0] a);
        wr_hit = stroke & (addr == a);
    endfunction : wr_hit

    wire mode_toggle = mode_select_first ^ mode_sel_q;
    wire pass_clear = emul.removal | emul.mode_change;
    // pass flag only while armed; re-arm needs a mode select toggle or a mode change
    wire pass_flag = (outcome == cpsf_pkg::CPSF_PASS) & pass_armed;
    wire dcp_flag = (outcome == cpsf_pkg::CPSF_DCP);
    wire custom_profile_flag_flag = (outcome == cpsf_pkg::CPSF_CUSTOM_PROFILE_FLAG);

    // the no-handshake verdict leaves the outcome alone, so a charging flag can report alongside it
    assign next_outcome = pass_clear ? cpsf_pkg::CPSF_IDLE
        : emul.custom_profile_flag_accept ? cpsf_pkg::CPSF_CUSTOM_PROFILE_FLAG
        : emul.dcp_accept ? cpsf_pkg::CPSF_DCP
        : pass_mode ? cpsf_pkg::CPSF_PASS
        : (outcome == cpsf_pkg::CPSF_PASS) ? cpsf_pkg::CPSF_IDLE
        : outcome;

    // cpdf and supply-low bits are not defined here and read zero
    wire [7:0] status = {no_handshake_flag, 2'b00, 1'b0, custom_profile_flag_flag, dcp_flag, 1'b0,
                         pass_flag};
    wire [3:0] new_events = {emul.cycle_no_handshake_flag, emul.custom_profile_flag_accept,
                             emul.dcp_accept,
                             pass_mode & pass_armed & ~pass_flag};

    wire next_hs = custom_profile_flag_flag ? control[cpsf_pkg::BIT_CUSTOM_PROFILE_FLAG_HS]
        : dcp_flag ? control[cpsf_pkg::BIT_HS_EMUL]
        : (outcome == cpsf_pkg::CPSF_PASS);
    wire next_const = custom_profile_flag_flag ? control[cpsf_pkg::BIT_CUSTOM_PROFILE_FLAG_CONST]
        : dcp_flag;

    wire [31:0] rd_mux = (paddr == cpsf_pkg::ADDR_STATUS) ? {24'h0, status}
        : (paddr == cpsf_pkg::ADDR_CONTROL) ? {29'h0, control}
        : (paddr == cpsf_pkg::ADDR_EVENT) ? {28'h0, events}
        : (paddr == cpsf_pkg::ADDR_MASK) ? {28'h0, mask}
        : 32'h0;
    wire [3:0] ev_clear = wr_hit(wr_stroke, paddr, cpsf_pkg::ADDR_EVENT)
        ? pwdata[3:0] : 4'h0;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            outcome <= cpsf_pkg::CPSF_IDLE;
        else
            outcome <= next_outcome;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            no_handshake_flag <= 1'b0;
        else if (emul.cycle_no_handshake_flag)
            no_handshake_flag <= 1'b1;
        // mode change or removal ends the outcome, no-handshake too
        else if (emul.new_profile | pass_clear)
            no_handshake_flag <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            pass_armed <= 1'b1;
        else if (mode_toggle | emul.mode_change)
            pass_armed <= 1'b1;
        else if (emul.removal)
            pass_armed <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            mode_sel_q <= 1'b0;
        else
            mode_sel_q <= mode_select_first;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            control <= cpsf_pkg::CONTROL_RESET;
        else if (wr_hit(wr_stroke, paddr, cpsf_pkg::ADDR_CONTROL))
            control <= pwdata[2:0];
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            mask <= cpsf_pkg::EVENT_RESET;
        else if (wr_hit(wr_stroke, paddr, cpsf_pkg::ADDR_MASK))
            mask <= pwdata[3:0];
    end

    // set beats a write-one clear in the same cycle
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            events <= cpsf_pkg::EVENT_RESET;
        else
            events <= (events & ~ev_clear) | new_events;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hs_switch_closed <= 1'b0;
            const_current_limit <= 1'b0;
            irq <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            hs_switch_closed <= next_hs;
            const_current_limit <= next_const;
            irq <= |(events & mask);
            prdata <= rd_stroke ? 32'h0 : rd_mux;
            pready <= 1'b1;
            pslverr <= 1'b0;
        end
    end

    // pready constant high: data settles during setup and stands
    wire unused_in = supply_low | charging_downstream | addr_hit;

    nohs_set_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        emul.cycle_no_handshake_flag |=> no_handshake_flag)
        else $error("no-handshake flag not set");
    nohs_clear_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        emul.new_profile && !emul.cycle_no_handshake_flag |=> !no_handshake_flag)
        else $error("no-handshake flag not cleared");
    custom_profile_flag_flag_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        emul.custom_profile_flag_accept && !pass_clear |=> status[cpsf_pkg::BIT_CUSTOM_PROFILE_FLAG])
        else $error("custom flag missing");
    custom_profile_flag_hs_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        custom_profile_flag_flag
        |=> hs_switch_closed == $past(control[cpsf_pkg::BIT_CUSTOM_PROFILE_FLAG_HS]))
        else $error("custom switch wrong");
    custom_profile_flag_limit_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        custom_profile_flag_flag
        |=> const_current_limit == $past(control[cpsf_pkg::BIT_CUSTOM_PROFILE_FLAG_CONST]))
        else $error("custom limit wrong");
    dcp_hs_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        dcp_flag
        |=> hs_switch_closed == $past(control[cpsf_pkg::BIT_HS_EMUL]))
        else $error("dcp switch wrong");
    dcp_limit_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        dcp_flag |=> const_current_limit)
        else $error("dcp not constant limit");
    pass_port_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        pass_flag |=> hs_switch_closed && !const_current_limit)
        else $error("pass-through port wrong");
    pass_hold_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        emul.removal && !mode_toggle && !emul.mode_change
        ##1 (!mode_toggle && !emul.mode_change) [*2] |-> !pass_flag)
        else $error("pass flag set after reattach");
    pass_rearm_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        mode_toggle && !emul.removal |=> pass_armed)
        else $error("pass flag not re-armed");
    status_zero_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        prdata[6:5] == 2'b00)
        else $error("reserved bits nonzero");
endmodule : cpsf_top

// ### bench/cpsf_device_model.sv
/*
 * behavioural portable device and emulation engine on the port lines.
 * assumes the bench asks for each emulation cycle and each plug event.
 */
`timescale 1ns/10ps
module cpsf_device_model
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // requests from the bench
    input wire logic start,
    input wire logic [1:0] answer,
    input wire logic [3:0] delay,
    input wire logic [2:0] ev,
    // engine events
    output cpsf_pkg::cpsf_emul_type emul
);
    logic [4:0] count;

    // answer 0 never handshakes, 1 takes dcp, 2 takes custom
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= 5'h00;
            emul <= '0;
        end
        else
        begin
            emul.removal <= ev[0];
            emul.attach <= ev[1];
            emul.mode_change <= ev[2];
            emul.new_profile <= start;
            if (start)
                count <= {1'b0, delay} + 5'h01;
            else if (count != 5'h00)
                count <= count - 5'h01;
            // slow device: the verdict comes delay cycles late
            emul.dcp_accept <= (count == 5'h01) && (answer == 2'h1);
            emul.custom_profile_flag_accept <= (count == 5'h01) && (answer == 2'h2);
            emul.cycle_no_handshake_flag <= (count == 5'h01) && (answer == 2'h0);
        end
    end
endmodule : cpsf_device_model

// ### bench/cpsf_top_tb.sv
/*
 * self-checking bench for the profile status flags block.
 * assumes the device model beside it and a 50 MHz core clock.
 */
`timescale 1ns/10ps
`define CHECK(got, exp, msg) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("[FAIL] %0t %s", $time, msg); \
        end \
    end
module cpsf_top_tb;
    logic core_clk = 1'b0, reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, hs_switch_closed, const_current_limit, irq;
    logic pass_mode = 1'b0, mode_select_first = 1'b0, start = 1'b0;
    logic [1:0] answer = 2'h0;
    logic [3:0] delay = 4'h0;
    logic [2:0] ev = 3'h0;
    cpsf_pkg::cpsf_emul_type emul;
    int mismatches = 0, tests_run = 0, cycles = 0;

    always #10 core_clk = ~core_clk;

    cpsf_top uut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pass_mode(pass_mode), .mode_select_first(mode_select_first),
        .supply_low(1'b0), .charging_downstream(1'b0), .emul(emul),
        .hs_switch_closed(hs_switch_closed),
        .const_current_limit(const_current_limit), .irq(irq));

    cpsf_device_model dev (.core_clk(core_clk), .reset_n(reset_n),
        .start(start), .answer(answer), .delay(delay), .ev(ev),
        .emul(emul));

    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        `CHECK(rdata, e, "read data")
    endtask : rd

    task automatic port(input logic hs, input logic cl);
        `CHECK(hs_switch_closed, hs, "hs switch")
        `CHECK(const_current_limit, cl, "limit mode")
    endtask : port

    task automatic run(input logic [1:0] an, input logic [3:0] dl,
        input int w);
        answer <= an;
        delay <= dl;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (w) @(posedge core_clk);
    endtask : run

    task automatic pulse(input logic [2:0] k);
        ev <= k;
        @(posedge core_clk);
        ev <= 3'h0;
        repeat (3) @(posedge core_clk);
    endtask : pulse

    task automatic test_regs;
        rd(cpsf_pkg::ADDR_STATUS, 32'h0);
        rd(8'h10, 32'h0);
        apb(cpsf_pkg::ADDR_STATUS, 1'b1, 32'hFFFFFFFF);
        rd(cpsf_pkg::ADDR_STATUS, 32'h0);
        `CHECK(pslverr, 1'b0, "slave error")
    endtask : test_regs

    task automatic test_dcp;
        apb(cpsf_pkg::ADDR_CONTROL, 1'b1, 32'h1);
        run(2'h1, 4'h0, 4);
        rd(cpsf_pkg::ADDR_STATUS, 32'h04);
        port(1'b1, 1'b1);
        `CHECK(irq, 1'b0, "masked irq")
        rd(cpsf_pkg::ADDR_EVENT, 32'h2);
        apb(cpsf_pkg::ADDR_MASK, 1'b1, 32'h2);
        @(posedge core_clk);
        `CHECK(irq, 1'b1, "irq raised")
        apb(cpsf_pkg::ADDR_CONTROL, 1'b1, 32'h0);
        @(posedge core_clk);
        port(1'b0, 1'b1);
        apb(cpsf_pkg::ADDR_EVENT, 1'b1, 32'h2);
        @(posedge core_clk);
        `CHECK(irq, 1'b0, "irq cleared")
    endtask : test_dcp

    task automatic test_custom_profile_flag;
        pulse(3'h4);
        for (int i = 0; i < 4; i++)
        begin
            apb(cpsf_pkg::ADDR_CONTROL, 1'b1, 32'(i * 2));
            run(2'h2, 4'h2, 6);
            rd(cpsf_pkg::ADDR_STATUS, 32'h08);
            port(i[0], i[1]);
        end
    endtask : test_custom_profile_flag

    task automatic test_nohs;
        pulse(3'h4);
        run(2'h0, 4'h1, 5);
        rd(cpsf_pkg::ADDR_STATUS, 32'h80);
        // slow device: verdict still pending while we read
        run(2'h0, 4'hF, 1);
        rd(cpsf_pkg::ADDR_STATUS, 32'h00);
        repeat (16) @(posedge core_clk);
        rd(cpsf_pkg::ADDR_STATUS, 32'h80);
    endtask : test_nohs

    task automatic test_pass;
        pulse(3'h4);
        pass_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(cpsf_pkg::ADDR_STATUS, 32'h01);
        port(1'b1, 1'b0);
        pulse(3'h1);
        pulse(3'h2);
        rd(cpsf_pkg::ADDR_STATUS, 32'h00);
        mode_select_first <= ~mode_select_first;
        repeat (3) @(posedge core_clk);
        rd(cpsf_pkg::ADDR_STATUS, 32'h01);
        pass_mode <= 1'b0;
    endtask : test_pass

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // generous ceiling: the full run needs under two hundred cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            summarize();
        end
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        test_regs();
        test_dcp();
        test_custom_profile_flag();
        test_nohs();
        test_pass();
        summarize();
    end
endmodule : cpsf_top_tb
